// [rtl/pll_ld_pkg.sv]
// package: register map, field layout, timing constants and carriers of the lock/mode block
package pll_ld_pkg;

   // clock and window timing
   localparam int unsigned CLK_PERIOD_PS = 20000;
   localparam int unsigned ANALOG_WINDOW_NS = 10;
   localparam logic [11:0] ANALOG_WINDOW_TENTHS = 12'(ANALOG_WINDOW_NS * 10);

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_INT_DIV = 6'h03;
   localparam logic [5:0] IDX_FWD = 6'h05;
   localparam logic [5:0] IDX_MOD = 6'h06;
   localparam logic [5:0] IDX_LD = 6'h07;
   localparam logic [5:0] IDX_PRE = 6'h08;
   localparam logic [5:0] IDX_CP = 6'h09;
   localparam logic [5:0] IDX_CSP = 6'h0b;
   localparam logic [5:0] IDX_PIN = 6'h0f;
   localparam logic [5:0] IDX_STATUS = 6'h12;

   // field positions
   localparam int LD_THR_LSB = 0;
   localparam int LD_EN_BIT = 3;
   localparam int LD_DIGITAL_BIT = 6;
   localparam int LD_SIZE_LSB = 7;
   localparam int LD_SPEED_LSB = 10;
   localparam int MOD_EN_BIT = 11;
   localparam int MOD_BYPASS_BIT = 7;
   localparam int PRE_DIV2_BIT = 19;
   localparam int CSP_THR_LSB = 7;
   localparam int PIN_MUX_EN_BIT = 7;
   localparam int PIN_KEEP_BIT = 6;
   localparam logic [4:0] PIN_SEL_LOCK = 5'h01;
   localparam int FWD_ADDR_LSB = 3;
   localparam int FWD_DATA_LSB = 7;
   localparam logic [3:0] VCO_IDX_PWR = 4'h1;
   localparam logic [3:0] VCO_IDX_DIV = 4'h2;
   localparam int VCO_DIFF_EN_BIT = 8;
   localparam int ST_INT_BIT = 0;
   localparam int ST_LOCK_BIT = 1;
   localparam int ST_FRAC_BIT = 2;

   // divider limits and reset values
   localparam logic [18:0] INT_DIV_MIN_INT = 19'h0_0010;
   localparam logic [18:0] INT_DIV_MIN_FRAC = 19'h0_0014;
   localparam logic [18:0] RST_INT_DIV = 19'h0_0014;
   localparam logic [31:0] RST_REG = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // charge-pump settings carried to the analog side
   typedef struct packed {
      logic [1:0] offset_dir;
      logic [6:0] offset_mag;
      logic [6:0] gain_up;
      logic [6:0] gain_dn;
   } cp_cfg_type;

   // oscillator subsystem settings reached by forwarding
   typedef struct packed {
      logic diff_div_enable;
      logic [2:0] out_div_sel;
   } vco_cfg_type;

   // synthesis mode flags
   typedef struct packed {
      logic integer_mode;
      logic fractional_mode;
      logic sigma_delta_on;
      logic step_is_comparison;
   } mode_type;

   // window timer state
   typedef struct packed {
      logic running;
      logic [4:0] elapsed;
   } timer_state_type;
   localparam timer_state_type TIMER_RST = '{default: '0};

   // whole state of the top block
   typedef struct packed {
      logic awready, wready, arready;
      logic aw_held, w_held;
      logic [5:0] aw_idx;
      logic [31:0] wdata_h;
      logic [3:0] wstrb_h;
      logic bvalid, rvalid;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
      logic [18:0] int_div;
      logic [31:0] reg_fwd, reg_mod, reg_ld, reg_pre, reg_cp, reg_csp, reg_pin;
      vco_cfg_type vco;
      mode_type mode;
      logic lock, pending, pending_ref, sdo, boost;
      logic [2:0] count;
   } top_state_type;
   localparam top_state_type TOP_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                         int_div: RST_INT_DIV, default: '0};

   // word index from a byte address
   function automatic logic [5:0] reg_idx(input logic [7:0] addr);
      return addr[7:2];
   endfunction : reg_idx

   // nominal digital window in tenths of a nanosecond
   function automatic logic [11:0] window_tenths(input logic [1:0] speed, input logic [2:0] size);
      logic [11:0] t [0:31];
      t = '{12'd65, 12'd80, 12'd110, 12'd170, 12'd290, 12'd530, 12'd1000, 12'd1950,
            12'd70, 12'd89, 12'd128, 12'd210, 12'd360, 12'd680, 12'd1300, 12'd2550,
            12'd71, 12'd92, 12'd133, 12'd220, 12'd380, 12'd720, 12'd1380, 12'd2720,
            12'd76, 12'd102, 12'd154, 12'd260, 12'd470, 12'd880, 12'd1720, 12'd3380};
      return t[{speed, size}];
   endfunction : window_tenths

   // longest window rounds down to whole cycles, never below one
   function automatic logic [4:0] window_cycles(input logic [11:0] tenths);
      int unsigned c;
      c = (int'(tenths) * 100) / CLK_PERIOD_PS;
      if (c < 1) begin
         c = 1;
      end
      return 5'(c);
   endfunction : window_cycles
endpackage : pll_ld_pkg

// [rtl/lock_window_timer.sv]
// lock_window_timer: counts cycles since the first edge of a pair opened a window
`timescale 1ns/1ps
module lock_window_timer
   import pll_ld_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic stop,
   input wire logic [4:0] win_len,
   output logic running,
   output logic [4:0] elapsed
);
   timer_state_type s_r; // registered state
   timer_state_type s_nxt; // next state

   // stop wins; start loads one; otherwise count up, saturating
   always_comb begin
      s_nxt = s_r;
      if (stop) begin
         s_nxt.running = 1'b0;
         s_nxt.elapsed = 5'h00;
      end else if (start) begin
         s_nxt.running = 1'b1;
         s_nxt.elapsed = 5'h01;
      end else if (s_r.running && s_r.elapsed != 5'h1f) begin
         s_nxt.elapsed = s_r.elapsed + 5'h01;
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= TIMER_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign running = s_r.running;
   assign elapsed = s_r.elapsed;

   // the owner closes every window no later than its length; a cut length ends it at once
   a_window_bound: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.running && $stable(win_len) |-> s_r.elapsed <= win_len)
      else $error("window timer ran past its length");
endmodule : lock_window_timer

// [rtl/pll_lock_detect_mode_control.sv]
// pll_lock_detect_mode_control: register file, lock detector, pin mux and mode control
`timescale 1ns/1ps
module pll_lock_detect_mode_control
   import pll_ld_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic phase_comparator_ref_edge,
   input wire logic phase_comparator_fb_edge,
   input wire logic serial_read_active,
   input wire logic serial_read_data,
   output logic lock_indicator,
   output logic serial_data_out,
   output logic cycle_slip_guard_boost,
   output mode_type mode,
   output logic [18:0] int_divider,
   output logic prescaler_div2,
   output cp_cfg_type charge_pump,
   output vco_cfg_type oscillator_cfg
);
   top_state_type s_r; // registered state
   top_state_type s_nxt; // next state

   logic t_running; // window open
   logic [4:0] t_elapsed; // cycles since first edge
   logic [4:0] win_len; // window length in cycles
   logic ld_en; // detection enabled
   logic hit; // pair closed inside window
   logic miss; // window ran out
   logic open_win; // first edge of a pair
   logic other_edge; // the edge still awaited
   logic [2:0] cnt_inc; // saturated count plus one
   logic [4:0] csp_thr; // cycle-slip threshold in cycles
   logic wr_fire; // write address and data both in hand
   logic [5:0] wr_idx; // index being written
   logic [31:0] wr_data; // merged write word
   logic ar_take; // read address accepted
   logic [5:0] rd_idx; // index being read
   logic route_lock; // pin mux selects the lock flag

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // phase error that triggers the gain boost
   function automatic logic [4:0] csp_cycles(input logic [1:0] code);
      case (code)
         2'h0: return 5'h01;
         2'h1: return 5'h02;
         2'h2: return 5'h04;
         default: return 5'h08;
      endcase
   endfunction : csp_cycles

   // window length, enable, thresholds and pin routing from the config registers
   always_comb begin
      ld_en = s_r.reg_ld[LD_EN_BIT];
      if (s_r.reg_ld[LD_DIGITAL_BIT]) begin
         win_len = window_cycles(window_tenths(s_r.reg_ld[LD_SPEED_LSB +: 2],
                                               s_r.reg_ld[LD_SIZE_LSB +: 3]));
      end else begin
         win_len = window_cycles(ANALOG_WINDOW_TENTHS);
      end
      csp_thr = csp_cycles(s_r.reg_csp[CSP_THR_LSB +: 2]);
      route_lock = s_r.reg_pin[PIN_MUX_EN_BIT] &&
                   (s_r.reg_pin[4:0] == PIN_SEL_LOCK);
   end

   // window timer shared by lock detect and cycle-slip guard
   lock_window_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(open_win),
      .stop(!ld_en || hit || miss),
      .win_len(win_len),
      .running(t_running),
      .elapsed(t_elapsed)
   );

   // next state: bus slave, registers, lock detect, pin mux
   always_comb begin
      s_nxt = s_r;
      hit = 1'b0;
      miss = 1'b0;
      open_win = 1'b0;
      other_edge = s_r.pending_ref ? phase_comparator_fb_edge : phase_comparator_ref_edge;
      cnt_inc = (s_r.count == 3'h7) ? 3'h7 : s_r.count + 3'h1;

      // write channel: address and data taken in either order
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_held = 1'b1;
         s_nxt.aw_idx = reg_idx(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_held = 1'b1;
         s_nxt.wdata_h = s_axi_wdata;
         s_nxt.wstrb_h = s_axi_wstrb;
      end
      wr_fire = s_nxt.aw_held && s_nxt.w_held;
      wr_idx = s_nxt.aw_idx;
      wr_data = 32'h0000_0000;
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (wr_fire) begin
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         // address decode of the write
         if (wr_idx == IDX_INT_DIV) begin
            wr_data = merge({13'h0000, s_r.int_div}, s_nxt.wdata_h, s_nxt.wstrb_h);
            // out-of-range divider values are ignored
            if (s_r.mode.integer_mode ? (wr_data[18:0] >= INT_DIV_MIN_INT)
                                      : (wr_data[18:0] >= INT_DIV_MIN_FRAC)) begin
               s_nxt.int_div = wr_data[18:0];
            end
         end else if (wr_idx == IDX_FWD) begin
            wr_data = merge(s_r.reg_fwd, s_nxt.wdata_h, s_nxt.wstrb_h);
            s_nxt.reg_fwd = wr_data;
            // forward the word into the oscillator subsystem
            if (wr_data[FWD_ADDR_LSB +: 4] == VCO_IDX_DIV) begin
               s_nxt.vco.out_div_sel = wr_data[FWD_DATA_LSB +: 3];
            end else if (wr_data[FWD_ADDR_LSB +: 4] == VCO_IDX_PWR) begin
               s_nxt.vco.diff_div_enable =
                  wr_data[FWD_DATA_LSB + VCO_DIFF_EN_BIT];
            end
         end else if (wr_idx == IDX_MOD) begin
            wr_data = merge(s_r.reg_mod, s_nxt.wdata_h, s_nxt.wstrb_h);
            s_nxt.reg_mod = wr_data;
         end else if (wr_idx == IDX_LD) begin
            wr_data = merge(s_r.reg_ld, s_nxt.wdata_h, s_nxt.wstrb_h);
            s_nxt.reg_ld = wr_data;
         end else if (wr_idx == IDX_PRE) begin
            wr_data = merge(s_r.reg_pre, s_nxt.wdata_h, s_nxt.wstrb_h);
            s_nxt.reg_pre = wr_data;
         end else if (wr_idx == IDX_CP) begin
            wr_data = merge(s_r.reg_cp, s_nxt.wdata_h, s_nxt.wstrb_h);
            s_nxt.reg_cp = wr_data;
         end else if (wr_idx == IDX_CSP) begin
            wr_data = merge(s_r.reg_csp, s_nxt.wdata_h, s_nxt.wstrb_h);
            s_nxt.reg_csp = wr_data;
         end else if (wr_idx == IDX_PIN) begin
            wr_data = merge(s_r.reg_pin, s_nxt.wdata_h, s_nxt.wstrb_h);
            s_nxt.reg_pin = wr_data;
         end else if (wr_idx == IDX_STATUS) begin
            // read-only status: write accepted, no effect
            s_nxt.bresp = RESP_OKAY;
         end else begin
            // unmapped address
            s_nxt.bresp = RESP_SLVERR;
         end
      end
      s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

      // read channel
      ar_take = s_axi_arvalid && s_r.arready;
      rd_idx = reg_idx(s_axi_araddr);
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (ar_take) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         s_nxt.rdata = 32'h0000_0000;
         // address decode of the read
         if (rd_idx == IDX_INT_DIV) begin
            s_nxt.rdata = {13'h0000, s_r.int_div};
         end else if (rd_idx == IDX_FWD) begin
            s_nxt.rdata = s_r.reg_fwd;
         end else if (rd_idx == IDX_MOD) begin
            s_nxt.rdata = s_r.reg_mod;
         end else if (rd_idx == IDX_LD) begin
            s_nxt.rdata = s_r.reg_ld;
         end else if (rd_idx == IDX_PRE) begin
            s_nxt.rdata = s_r.reg_pre;
         end else if (rd_idx == IDX_CP) begin
            s_nxt.rdata = s_r.reg_cp;
         end else if (rd_idx == IDX_CSP) begin
            s_nxt.rdata = s_r.reg_csp;
         end else if (rd_idx == IDX_PIN) begin
            s_nxt.rdata = s_r.reg_pin;
         end else if (rd_idx == IDX_STATUS) begin
            s_nxt.rdata[ST_INT_BIT] = s_r.mode.integer_mode;
            s_nxt.rdata[ST_LOCK_BIT] = s_r.lock;
            s_nxt.rdata[ST_FRAC_BIT] = s_r.mode.fractional_mode;
         end else begin
            s_nxt.rresp = RESP_SLVERR;
         end
      end
      s_nxt.arready = !s_nxt.rvalid;

      // lock detector: pair of edges inside one window
      if (!ld_en) begin
         s_nxt.lock = 1'b0;
         s_nxt.count = 3'h0;
         s_nxt.pending = 1'b0;
      end else if (!s_r.pending) begin
         // either edge may come first; both at once is a hit
         if (phase_comparator_ref_edge && phase_comparator_fb_edge) begin
            hit = 1'b1;
         end else if (phase_comparator_ref_edge || phase_comparator_fb_edge) begin
            open_win = 1'b1;
            s_nxt.pending = 1'b1;
            s_nxt.pending_ref = phase_comparator_ref_edge;
         end
      end else begin
         // an edge on the last open cycle still counts
         if (other_edge && t_elapsed <= win_len) begin
            hit = 1'b1;
         end else if (t_elapsed >= win_len) begin
            miss = 1'b1;
         end
         if (hit || miss) begin
            s_nxt.pending = 1'b0;
         end
      end
      if (hit) begin
         s_nxt.count = cnt_inc;
         s_nxt.lock = s_r.lock || (cnt_inc >= s_r.reg_ld[LD_THR_LSB +: 3]);
      end
      if (miss) begin
         s_nxt.count = 3'h0;
         s_nxt.lock = 1'b0;
      end

      // gain boost while the phase error stays past the threshold
      s_nxt.boost = s_r.pending && t_running && (t_elapsed > csp_thr) && !hit && !miss;

      // output pin: lock flag, or read data while a read borrows it
      if (s_r.reg_pin[PIN_KEEP_BIT]) begin
         s_nxt.sdo = s_r.lock;
      end else if (serial_read_active) begin
         s_nxt.sdo = serial_read_data;
      end else if (route_lock) begin
         s_nxt.sdo = s_r.lock;
      end else begin
         s_nxt.sdo = 1'b0;
      end

      // modulator mode from the control register as it will stand
      s_nxt.mode.integer_mode = !s_nxt.reg_mod[MOD_EN_BIT] && s_nxt.reg_mod[MOD_BYPASS_BIT];
      s_nxt.mode.fractional_mode = s_nxt.reg_mod[MOD_EN_BIT] &&
                                   !s_nxt.reg_mod[MOD_BYPASS_BIT];
      s_nxt.mode.sigma_delta_on = !s_nxt.mode.integer_mode && s_nxt.reg_mod[MOD_EN_BIT];
      s_nxt.mode.step_is_comparison = s_nxt.mode.integer_mode;
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= TOP_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign lock_indicator = s_r.lock;
   assign serial_data_out = s_r.sdo;
   assign cycle_slip_guard_boost = s_r.boost;
   assign mode = s_r.mode;
   assign int_divider = s_r.int_div;
   assign prescaler_div2 = s_r.reg_pre[PRE_DIV2_BIT];
   assign charge_pump.gain_dn = s_r.reg_cp[6:0];
   assign charge_pump.gain_up = s_r.reg_cp[13:7];
   assign charge_pump.offset_mag = s_r.reg_cp[20:14];
   assign charge_pump.offset_dir = s_r.reg_cp[22:21];
   assign oscillator_cfg = s_r.vco;

   a_ld_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
      !ld_en |=> !lock_indicator && s_r.count == 3'h0)
      else $error("lock state not cleared while detection disabled");
   a_miss_unlock: assert property (@(posedge aclk) disable iff (!aresetn)
      miss |=> !lock_indicator ##1 (!serial_data_out || !route_lock || $past(serial_read_active)))
      else $error("missed window did not drop lock");
   a_keep_lock_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.reg_pin[PIN_KEEP_BIT] && !wr_fire |=> serial_data_out == $past(lock_indicator))
      else $error("pin does not follow lock in keep mode");
   a_read_on_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      !s_r.reg_pin[PIN_KEEP_BIT] && serial_read_active && !wr_fire
      |=> serial_data_out == $past(serial_read_data))
      else $error("read data not on pin during read");
   a_integer_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      mode.integer_mode |-> !s_r.reg_mod[MOD_EN_BIT] && !mode.sigma_delta_on && !mode.fractional_mode)
      else $error("integer mode with modulator running");
   a_fractional_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.reg_mod[MOD_EN_BIT] && !s_r.reg_mod[MOD_BYPASS_BIT] |-> mode.fractional_mode)
      else $error("fractional mode not in effect");
   a_forward_div: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_idx == IDX_FWD && wr_data[FWD_ADDR_LSB +: 4] == VCO_IDX_DIV
      |=> oscillator_cfg.out_div_sel == $past(wr_data[FWD_DATA_LSB +: 3]))
      else $error("forwarded divider select not applied");
   a_csp_boost: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.pending && t_elapsed > 5'h08 && !hit && !miss |=> cycle_slip_guard_boost)
      else $error("gain boost missing past threshold");
   a_boost_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      !s_r.pending |=> !cycle_slip_guard_boost)
      else $error("gain boost without an open window");
   a_pin_routed: assert property (@(posedge aclk) disable iff (!aresetn)
      route_lock && !s_r.reg_pin[PIN_KEEP_BIT] && !serial_read_active
      |=> serial_data_out == $past(lock_indicator))
      else $error("routed pin does not follow lock");
   a_status_lock: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_take && rd_idx == IDX_STATUS |=> s_axi_rdata[ST_LOCK_BIT] == $past(s_r.lock))
      else $error("status lock bit wrong");
   a_div_floor: assert property (@(posedge aclk) disable iff (!aresetn)
      int_divider >= INT_DIV_MIN_INT)
      else $error("integer divider below floor");
endmodule : pll_lock_detect_mode_control

// [test/edge_source.sv]
// host-side pulse source for the divided reference and oscillator edges
`timescale 1ns/1ps
module edge_source (
   input wire logic aclk,
   input wire logic run,
   input wire logic [3:0] gap,
   output logic ref_edge,
   output logic fb_edge
);
   logic [2:0] phase_r = 3'h0; // position in the 8-cycle period
   initial ref_edge = 1'b0;
   initial fb_edge = 1'b0;
   // ref at phase 0, feedback gap cycles later; a gap above 7 never lands
   always @(posedge aclk) begin
      phase_r <= phase_r + 3'h1;
      ref_edge <= run && phase_r == 3'h0;
      fb_edge <= run && {1'b0, phase_r} == gap;
   end
endmodule : edge_source

// [test/pll_lock_detect_mode_control_tb.sv]
// bench for the lock detector, pin mux and mode control
`timescale 1ns/1ps
module pll_lock_detect_mode_control_tb;
   import pll_ld_pkg::*;
   logic aclk = 0, aresetn = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, phase_comparator_ref_edge, phase_comparator_fb_edge;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic serial_read_active = 0, serial_read_data = 0, run = 0;
   logic lock_indicator, serial_data_out, cycle_slip_guard_boost, prescaler_div2;
   mode_type mode;
   logic [18:0] int_divider;
   cp_cfg_type charge_pump;
   vco_cfg_type oscillator_cfg;
   logic [3:0] gap = 4'h2; // feedback two cycles after reference
   logic [31:0] rd;
   int fail_count = 0, cmp_count = 0;
   pll_lock_detect_mode_control dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .phase_comparator_ref_edge(phase_comparator_ref_edge),
      .phase_comparator_fb_edge(phase_comparator_fb_edge),
      .serial_read_active(serial_read_active), .serial_read_data(serial_read_data),
      .lock_indicator(lock_indicator), .serial_data_out(serial_data_out),
      .cycle_slip_guard_boost(cycle_slip_guard_boost), .mode(mode),
      .int_divider(int_divider), .prescaler_div2(prescaler_div2),
      .charge_pump(charge_pump), .oscillator_cfg(oscillator_cfg));
   edge_source partner (.aclk(aclk), .run(run), .gap(gap),
      .ref_edge(phase_comparator_ref_edge), .fb_edge(phase_comparator_fb_edge));
   // 50 MHz clock
   initial forever #10 aclk = ~aclk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, s);
         fail_count++;
      end
   endtask : chk
   // one write; address and data released when each is taken
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask : wr
   // one read; data and response taken at the rvalid edge
   task automatic rdw(input logic [5:0] i);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdw
   task automatic settle;
      repeat (40) @(posedge aclk);
   endtask : settle
   task automatic t_regs;
      chk("int_divider reset", RST_INT_DIV, int_divider);
      wr(IDX_CP, 32'h0034_3264);
      chk("bresp okay", RESP_OKAY, rs);
      chk("charge_pump", {2'b01, 7'h50, 7'h64, 7'h64}, charge_pump);
      wr(IDX_FWD, 32'h0000_0190);
      wr(IDX_FWD, 32'h0000_8008);
      chk("oscillator_cfg", 4'b1011, oscillator_cfg);
      wr(IDX_PRE, 32'h0008_0000);
      chk("prescaler_div2", 1, prescaler_div2);
      rdw(6'h3f);
      chk("unmapped rresp", RESP_SLVERR, rs);
      chk("unmapped rdata", 0, rd);
      wr(6'h3f, 32'h0000_0001);
      chk("unmapped bresp", RESP_SLVERR, rs);
   endtask : t_regs
   task automatic t_mode;
      wr(IDX_CP, 32'h0000_3264);
      chk("charge_pump no offset", {2'b00, 7'h00, 7'h64, 7'h64}, charge_pump);
      wr(IDX_MOD, 32'h0000_0080);
      chk("mode integer", 4'b1001, mode);
      wr(IDX_INT_DIV, 32'h0000_0010);
      chk("divider 16", 16, int_divider);
      rdw(IDX_STATUS);
      chk("status integer", 3'b001, rd[2:0]);
      wr(IDX_MOD, 32'h0000_0800);
      chk("mode fractional", 4'b0110, mode);
      wr(IDX_INT_DIV, 32'h0000_0013);
      chk("divider kept", 16, int_divider);
   endtask : t_mode
   task automatic t_lock;
      wr(IDX_PIN, 32'h0000_0081);
      wr(IDX_LD, 32'h0000_000a);
      settle();
      chk("lock analog", 0, lock_indicator);
      wr(IDX_LD, 32'h0000_02ca);
      settle();
      chk("lock digital", 1, lock_indicator);
      chk("pin lock", 1, serial_data_out);
      rdw(IDX_STATUS);
      chk("status lock", 1, rd[1]);
      serial_read_active <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("pin read data", 0, serial_data_out);
      serial_read_active <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("pin after read", 1, serial_data_out);
      wr(IDX_PIN, 32'h0000_0040);
      serial_read_active <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("pin kept", 1, serial_data_out);
      serial_read_active <= 1'b0;
      wr(IDX_LD, 32'h0000_024a);
      settle();
      chk("lock short window", 0, lock_indicator);
      wr(IDX_LD, 32'h0000_02ca);
      settle();
      wr(IDX_LD, 32'h0000_02c2);
      chk("lock disabled", 0, lock_indicator);
   endtask : t_lock
   // cycle-slip guard: one threshold code, boost cycles over two 24-cycle periods
   task automatic t_csp(input logic [31:0] code, input int e);
      int n;
      n = 0;
      wr(IDX_CSP, code);
      settle();
      repeat (48) begin
         @(posedge aclk);
         if (cycle_slip_guard_boost === 1'b1) n++;
      end
      chk("boost cycles", e, n);
      chk("lock without feedback", 0, lock_indicator);
   endtask : t_csp
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   // main sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      run <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_mode();
      t_lock();
      gap <= 4'hf;
      wr(IDX_LD, 32'h0000_0fc8);
      t_csp(32'h0000_0180, 14);
      t_csp(32'h0000_0000, 28);
      close_out();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      close_out();
   end
endmodule : pll_lock_detect_mode_control_tb
